// >>> cmd_decode_map.svh
// command/address decode constants
`ifndef CMD_DECODE_MAP_SVH
`define CMD_DECODE_MAP_SVH
`define AP_BIT 10
`define BC_BIT 12
`define ROW_HI_LSB 14
// command encodings of {ras_n, cas_n, we_n} with act_n high
`define ENC_MRS 3'h0
`define ENC_REF 3'h1
`define ENC_PRE 3'h2
`define ENC_RSVD 3'h3
`define ENC_WR 3'h4
`define ENC_RD 3'h5
`define ENC_ZQC 3'h6
`define ENC_NOP 3'h7
// stack organisations
`define STACK_MONO 2'h0
`define STACK_DDP 2'h1
`define STACK_3DS 2'h2
`endif

// >>> cmd_decode_pkg.sv
// types for the command/address decode
package cmd_decode_pkg;
    typedef enum logic [7:0] {
        CMD_NONE = 8'h01,
        CMD_ACT = 8'h02,
        CMD_RD = 8'h04,
        CMD_WR = 8'h08,
        CMD_PRE = 8'h10,
        CMD_MRS = 8'h20,
        CMD_REF = 8'h40,
        CMD_OTHER = 8'h80
    } cmd_t;

    typedef struct packed {
        logic cs_n;
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] addr;
        logic [2:0] stack;
    } ca_in_t;

    typedef struct packed {
        cmd_t cmd;
        logic [17:0] row;
        logic [9:0] col;
        logic [17:0] opcode;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [3:0] mr_sel;
        logic auto_pre;
        logic all_banks;
        logic chop;
        logic [2:0] chip_id;
        logic die1_cs_n;
        logic die1_cke;
        logic die1_odt;
    } dec_out_t;
endpackage : cmd_decode_pkg

// >>> sdram_cmd_addr_decode.sv
// command and address input decode of the memory device
`timescale 1ns/1ps
`include "cmd_decode_map.svh"
module sdram_cmd_addr_decode #(
    parameter int ROW_BITS = 17,
    parameter int COL_BITS = 10,
    parameter logic X16 = 1'b0,
    parameter logic [1:0] STACK_MODE = `STACK_MONO,
    parameter logic [2:0] DIE_ID = 3'h0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command/address pins, one sample per rising edge
    input wire cmd_decode_pkg::ca_in_t ca,
    // decoded command
    output cmd_decode_pkg::dec_out_t dec,
    output logic dec_valid
);

    ////////////////////////////////////////////////////////////////////////////////
    // masks for bits that do not exist on this part
    localparam logic [17:0] ROW_MASK = 18'((1 << ROW_BITS) - 1);
    localparam logic [9:0] COL_MASK = 10'((1 << COL_BITS) - 1);
    localparam logic [1:0] BG_MASK = X16 ? 2'h1 : 2'h3;

    logic [17:0] addr_q;
    logic [2:0] hi_bits;
    logic [1:0] bg_eff;
    logic die_sel;
    cmd_decode_pkg::cmd_t next_cmd;

    // upper row bits come from the command pins on activate
    assign hi_bits = {ca.ras_n, ca.cas_n, ca.we_n};
    assign bg_eff = ca.bg & BG_MASK;
    // a single-load stack answers only to its own chip id
    assign die_sel = (STACK_MODE == `STACK_3DS) ? (ca.stack == DIE_ID) : 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // command type from chip select, activate and the encoding pins
    always_comb begin
        next_cmd = cmd_decode_pkg::CMD_NONE;
        if (!ca.cs_n && die_sel) begin
            if (!ca.act_n) begin
                next_cmd = cmd_decode_pkg::CMD_ACT;
            end else begin
                unique case (hi_bits)
                    `ENC_MRS: next_cmd = cmd_decode_pkg::CMD_MRS;
                    `ENC_REF: next_cmd = cmd_decode_pkg::CMD_REF;
                    `ENC_PRE: next_cmd = cmd_decode_pkg::CMD_PRE;
                    `ENC_WR: next_cmd = cmd_decode_pkg::CMD_WR;
                    `ENC_RD: next_cmd = cmd_decode_pkg::CMD_RD;
                    `ENC_NOP: next_cmd = cmd_decode_pkg::CMD_NONE;
                    default: next_cmd = cmd_decode_pkg::CMD_OTHER;
                endcase
            end
        end
    end

    // on activate the command pins stand in for A16..A14
    always_comb begin
        addr_q = ca.addr;
        if (!ca.act_n) begin
            addr_q[`ROW_HI_LSB +: 3] = hi_bits;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // captured decode, one result per rising edge
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dec <= '0;
            dec.cmd <= cmd_decode_pkg::CMD_NONE;
            dec_valid <= 1'b0;
        end else begin
            dec.cmd <= next_cmd;
            dec_valid <= next_cmd != cmd_decode_pkg::CMD_NONE;
            dec.row <= addr_q & ROW_MASK;
            dec.col <= ca.addr[9:0] & COL_MASK;
            dec.opcode <= ca.addr;
            dec.bg <= bg_eff;
            dec.ba <= ca.ba;
            dec.mr_sel <= {bg_eff, ca.ba};
            // auto-precharge only means something on reads and writes
            dec.auto_pre <= (next_cmd == cmd_decode_pkg::CMD_RD ||
                next_cmd == cmd_decode_pkg::CMD_WR) && ca.addr[`AP_BIT];
            dec.all_banks <= next_cmd == cmd_decode_pkg::CMD_PRE && ca.addr[`AP_BIT];
            dec.chop <= (next_cmd == cmd_decode_pkg::CMD_RD ||
                next_cmd == cmd_decode_pkg::CMD_WR) && !ca.addr[`BC_BIT];
            dec.chip_id <= (STACK_MODE == `STACK_3DS) ? ca.stack : 3'h0;
            // dual-die: C1 is cs1_n, C0 cke1, C2 odt1, passed through registered
            dec.die1_cs_n <= (STACK_MODE == `STACK_DDP) ? ca.stack[1] : 1'b1;
            dec.die1_cke <= (STACK_MODE == `STACK_DDP) ? ca.stack[0] : 1'b0;
            dec.die1_odt <= (STACK_MODE == `STACK_DDP) ? ca.stack[2] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    a_cs_masks: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ca.cs_n |=> !dec_valid && dec.cmd == cmd_decode_pkg::CMD_NONE)
        else $error("command decoded with chip select high");
    a_act_decode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ca.cs_n && !ca.act_n && die_sel |=> dec.cmd == cmd_decode_pkg::CMD_ACT &&
        dec.row[16:14] == ($past(hi_bits) & ROW_MASK[16:14]))
        else $error("activate not decoded with upper row bits");
    a_rd_encode: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ca.cs_n && ca.act_n && die_sel && hi_bits == `ENC_RD |=>
        dec.cmd == cmd_decode_pkg::CMD_RD)
        else $error("read encoding not decoded");
    a_col_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> dec.col == ($past(ca.addr[9:0]) & COL_MASK))
        else $error("column address wrong");
    a_auto_pre: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dec.auto_pre |-> dec.cmd inside {cmd_decode_pkg::CMD_RD, cmd_decode_pkg::CMD_WR}
        && $past(ca.addr[`AP_BIT]))
        else $error("auto-precharge flag wrong");
    a_pre_all: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dec.cmd == cmd_decode_pkg::CMD_PRE |-> dec.all_banks == $past(ca.addr[`AP_BIT]))
        else $error("precharge scope wrong");
    a_burst_chop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dec.cmd == cmd_decode_pkg::CMD_RD |-> dec.chop == !$past(ca.addr[`BC_BIT]))
        else $error("burst chop wrong");
    a_mr_select: assert property (@(posedge sys_clk) disable iff (sys_rst)
        dec.cmd == cmd_decode_pkg::CMD_MRS |-> dec.mr_sel == {$past(bg_eff), $past(ca.ba)}
        && dec.opcode == $past(ca.addr))
        else $error("mode register select wrong");
    a_bg_mask: assert property (@(posedge sys_clk) disable iff (sys_rst)
        X16 |-> !dec.bg[1])
        else $error("upper bank group bit used on x16");
    a_bank_target: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> dec.ba == $past(ca.ba))
        else $error("bank address wrong");
    c_activate: cover property (@(posedge sys_clk) dec.cmd == cmd_decode_pkg::CMD_ACT);
    c_read_ap: cover property (@(posedge sys_clk) dec.cmd == cmd_decode_pkg::CMD_RD && dec.auto_pre);
    c_pre_all: cover property (@(posedge sys_clk) dec.all_banks);
    c_mrs: cover property (@(posedge sys_clk) dec.cmd == cmd_decode_pkg::CMD_MRS);

endmodule : sdram_cmd_addr_decode

// >>> ca_model.sv
// controller-side model that drives the command/address bus
`timescale 1ns/1ps
module ca_model (
    // clock
    input wire logic sys_clk,
    // command/address bus toward the device
    output cmd_decode_pkg::ca_in_t ca
);
    cmd_decode_pkg::ca_in_t next_ca;
    logic pending = 1'b0;
    ////////////////////////////////////////
    // launch on the falling edge so the sample is settled around the capturing rising edge;
    // between commands chip select stays high and the other lines keep toggling
    initial ca = '1;
    always @(negedge sys_clk) begin
        ca <= pending ? next_ca : {1'b1, ~ca[28:0]};
        pending <= 1'b0;
    end
    // the short delay keeps a back-to-back call from racing the launching edge
    task automatic send(input cmd_decode_pkg::ca_in_t c);
        next_ca = c;
        pending = 1'b1;
        @(negedge sys_clk);
        #1;
    endtask : send
endmodule : ca_model

// >>> testbench.sv
// self-checking bench for the command/address decode
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    cmd_decode_pkg::ca_in_t ca;
    cmd_decode_pkg::dec_out_t dec;
    cmd_decode_pkg::dec_out_t exp_q[$];
    logic dec_valid;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // command for each {ras_n, cas_n, we_n} with activate high
    localparam cmd_decode_pkg::cmd_t enc_map [8] = '{cmd_decode_pkg::CMD_MRS,
        cmd_decode_pkg::CMD_REF, cmd_decode_pkg::CMD_PRE, cmd_decode_pkg::CMD_OTHER,
        cmd_decode_pkg::CMD_WR, cmd_decode_pkg::CMD_RD, cmd_decode_pkg::CMD_OTHER,
        cmd_decode_pkg::CMD_NONE};
    always #12.5 sys_clk = ~sys_clk;
    ca_model ca_model_i (.sys_clk(sys_clk), .ca(ca));
    sdram_cmd_addr_decode sdram_cmd_addr_decode_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .ca(ca), .dec(dec), .dec_valid(dec_valid));
    ////////////////////////////////////////
    task automatic cmp(input string what, input logic [17:0] e, input logic [17:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic complete_run;
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    // note the expected decode, then hand the sample to the controller model
    task automatic send_cmd(input cmd_decode_pkg::ca_in_t c);
        cmd_decode_pkg::dec_out_t e;
        e = '0;
        e.cmd = c.cs_n ? cmd_decode_pkg::CMD_NONE : enc_map[{c.ras_n, c.cas_n, c.we_n}];
        if (!c.cs_n && !c.act_n) e.cmd = cmd_decode_pkg::CMD_ACT;
        e.row = {1'b0, c.ras_n, c.cas_n, c.we_n, c.addr[13:0]};
        e.col = c.addr[9:0];
        e.opcode = c.addr;
        e.bg = c.bg;
        e.ba = c.ba;
        e.mr_sel = {c.bg, c.ba};
        e.auto_pre = c.addr[10];
        e.all_banks = c.addr[10];
        e.chop = !c.addr[12];
        e.die1_cs_n = 1'b1;
        if (e.cmd != cmd_decode_pkg::CMD_NONE) exp_q.push_back(e);
        ca_model_i.send(c);
    endtask : send_cmd
    ////////////////////////////////////////
    // outputs are settled by the falling edge; each valid result takes the oldest note
    always @(negedge sys_clk) begin
        cycles++;
        if (cycles > 2000) begin
            bad_count++;
            complete_run();
        end else if (dec_valid === 1'b1 && exp_q.size() == 0) begin
            cmp("unexpected valid", 18'h0, 18'h1);
        end else if (dec_valid === 1'b1) begin
            automatic cmd_decode_pkg::dec_out_t e = exp_q.pop_front();
            cmp("cmd", 18'(e.cmd), 18'(dec.cmd));
            cmp("bank", 18'(e.mr_sel), 18'({dec.bg, dec.ba}));
            cmp("die1", 18'h20, 18'({dec.die1_cs_n, dec.die1_cke, dec.die1_odt, dec.chip_id}));
            case (e.cmd)
                cmd_decode_pkg::CMD_ACT: cmp("row", e.row, dec.row);
                cmd_decode_pkg::CMD_MRS: begin
                    cmp("opcode", e.opcode, dec.opcode);
                    cmp("mr_sel", 18'(e.mr_sel), 18'(dec.mr_sel));
                end
                cmd_decode_pkg::CMD_PRE: cmp("all", 18'(e.all_banks), 18'(dec.all_banks));
                cmd_decode_pkg::CMD_RD, cmd_decode_pkg::CMD_WR: begin
                    cmp("col", 18'(e.col), 18'(dec.col));
                    cmp("auto_pre", 18'(e.auto_pre), 18'(dec.auto_pre));
                    cmp("chop", 18'(e.chop), 18'(dec.chop));
                end
                default: ;
            endcase
        end
    end
    ////////////////////////////////////////
    initial begin
        cmd_decode_pkg::ca_in_t c;
        void'($urandom(74));
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst <= 1'b0;
        cmp("idle valid", 18'h0, 18'(dec_valid));
        // every encoding back to back, the ninth with activate low
        for (int i = 0; i < 9; i++) begin
            c = 30'($urandom());
            c.cs_n = 1'b0;
            c.act_n = (i != 8);
            {c.ras_n, c.cas_n, c.we_n} = i[2:0];
            send_cmd(c);
        end
        // random mix, deselected edges among them
        repeat (120) send_cmd(30'($urandom()));
        repeat (3) @(negedge sys_clk);
        cmp("pending", 18'h0, 18'(exp_q.size()));
        // a second reset mid-run must clear the decode and allow a command right after
        sys_rst <= 1'b1;
        repeat (2) @(negedge sys_clk);
        cmp("reset cmd", 18'(cmd_decode_pkg::CMD_NONE), 18'(dec.cmd));
        sys_rst <= 1'b0;
        repeat (10) send_cmd(30'($urandom()));
        repeat (3) @(negedge sys_clk);
        cmp("drained", 18'h0, 18'(exp_q.size()));
        complete_run();
    end
endmodule : testbench
